// File: logic/pzs_pkg.sv
// Purpose: Shared constants and types for the power zone phase shedding block.
// Assumes: 50 MHz mclk, 8-bit current and threshold codes.
// Notes: Register offsets are word indexes on the plain register port.
package pzs_pkg;
  // Register offsets.
  localparam logic [3:0] ADDR_THR1 = 4'h0;
  localparam logic [3:0] ADDR_THR2 = 4'h1;
  localparam logic [3:0] ADDR_THR3 = 4'h2;
  localparam logic [3:0] ADDR_THR4 = 4'h3;
  localparam logic [3:0] ADDR_HYST = 4'h4;
  localparam logic [3:0] ADDR_DELAY = 4'h5;
  localparam logic [3:0] ADDR_FREQ = 4'h6;
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_PHASES = 4'h9;
  // Reset values.
  localparam logic [7:0] THR_DISABLED = 8'hFF;
  localparam logic [7:0] HYST_RESET = 8'h10;
  localparam logic [7:0] DELAY_RESET = 8'h14;
  localparam logic [7:0] FREQ_RESET = 8'h00;
  localparam logic [2:0] FIXED_RESET = 3'h0;
  localparam logic [3:0] PHASES_RESET = 4'h8;
  // Timing: 10 us per delay step and per current sample.
  localparam int CLK_MHZ = 50;
  localparam int STEP_US = 10;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
  localparam logic [2:0] ZONE_DCM = 3'h4;
  typedef enum logic [1:0] {
    PZS_PS_LOW,
    PZS_PS_MID,
    PZS_PS_HIGH
  } pzs_psave_t;
  // Register port request bundle.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pzs_req_t;
endpackage : pzs_pkg

// File: logic/pzs_zone_ctrl.sv
// Purpose: Power zone selection and phase enable generation.
// Assumes: Current samples and power-save level synchronous to mclk.
// Notes: Zone 0 is all phases; zone 4 is the light-load DCM zone.
//
// Summary of operation
// (RULE_01) Eight phases: zone0 all, zone1 odd, zone2 phases 1 and 5, else 1.
// (RULE_02) Seven phases zone0 1-7; six phases zone0 1-6, zone2 1,3,5.
// (RULE_03) Five/three/two full at zone0; four zone2 1,3; one phase 1 only.
// (RULE_04) Zone 4 runs DCM at reduced frequency; others run CCM. Code only raises dcmMode; frequency stays the register value.
// (RULE_05) Mid power-save level picks the zone automatically from current.
// (RULE_06) Rising current moves toward a lower zone without added delay.
// (RULE_07) Falling current waits the programmable shed delay, 10 us steps.
// (RULE_08) Zones change one step at a time, each shed step delayed.
// (RULE_09) Lower zone above threshold; higher only below threshold minus hyst.
// (RULE_10) Hysteresis resets to 0x10 and software may rewrite it.
// (RULE_11) Zones with a disabled threshold are skipped while stepping.
// (RULE_12) Low power-save level fixed zone uses the same stepped procedure.
// (RULE_13) Fixed target zone is allowed even if disabled for auto shedding.
// (RULE_14) Frequency setting register is readable and writable.
// (RULE_15) High power-save level keeps all configured phases on.
// (RULE_16) Automatic mode samples current periodically against thresholds.
// (RULE_17) Writing 0xFF to a threshold disables it and its zone.
// (RULE_18) Delay restarts after each step; pending shed cancelled on rise.
// (RULE_19) Zone held encoded; phase enables derived from zone and count.
`timescale 1ns/100ps
module pzs_zone_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pzs_pkg::pzs_psave_t powerSaveSelect,
  input wire logic [7:0] totalCurrentMonitor,
  input wire pzs_pkg::pzs_req_t regReq,
  output logic [7:0] regRdata,
  output logic [7:0] phaseEnable,
  output logic dcmMode,
  output logic [7:0] switchingFrequencySetting,
  output logic [2:0] zone
);
  logic [7:0] thr_q [4];
  logic [7:0] hyst_q;
  logic [7:0] delay_q;
  logic [2:0] fixedZone_q;
  logic [3:0] phases_q;
  logic [2:0] zone_q;
  logic [2:0] target_q;
  logic [15:0] tick_q;
  logic sample;
  logic [7:0] stepCnt_q;
  logic [7:0] phaseEn_d;
  logic upNextOk;

  // Phase enable pattern for a zone and phase count.
  function automatic logic [7:0] phase_map(input logic [2:0] z,
                                           input logic [3:0] n);
    logic [7:0] all;
    all = 8'hFF >> (4'h8 - n);
    phase_map = 8'h01;
    if (z == 3'h0) begin
      phase_map = all; // RULE_01 RULE_02 RULE_03
    end else if (z == 3'h1 && n == 4'h8) begin
      phase_map = 8'h55; // RULE_01
    end else if (z == 3'h2 && n == 4'h8) begin
      phase_map = 8'h11; // RULE_01
    end else if (z == 3'h2 && n == 4'h6) begin
      phase_map = 8'h15; // RULE_02
    end else if (z == 3'h2 && n == 4'h4) begin
      phase_map = 8'h05; // RULE_03
    end
  endfunction : phase_map

  // A zone is usable when its pattern exists and its threshold is enabled.
  // Threshold k (1..4) guards zone 5-k, so zone 4 falls with threshold 1.
  function automatic logic zone_ok(input logic [2:0] z,
                                   input logic [3:0] n,
                                   input logic [7:0] t1,
                                   input logic [7:0] t2,
                                   input logic [7:0] t3,
                                   input logic [7:0] t4);
    logic exists;
    logic en;
    exists = 1'b1;
    if (z == 3'h1) begin
      exists = (n == 4'h8);
    end else if (z == 3'h2) begin
      exists = (n == 4'h8 || n == 4'h6 || n == 4'h4);
    end else if (z == 3'h3) begin
      exists = (n != 4'h1);
    end
    unique case (z)
      3'h1: en = (t4 != pzs_pkg::THR_DISABLED); // RULE_17
      3'h2: en = (t3 != pzs_pkg::THR_DISABLED); // RULE_17
      3'h3: en = (t2 != pzs_pkg::THR_DISABLED); // RULE_17
      3'h4: en = (t1 != pzs_pkg::THR_DISABLED); // RULE_17
      default: en = 1'b1;
    endcase
    zone_ok = exists && en;
  endfunction : zone_ok

  // One move from cur toward tgt. Unusable zones in between are passed
  // over so the block never dwells in them; the target itself is always
  // accepted, which lets fixed mode reach a zone that shedding disabled.
  function automatic logic [2:0] step_zone(input logic [2:0] cur,
                                           input logic [2:0] tgt,
                                           input logic [3:0] n,
                                           input logic [7:0] t1,
                                           input logic [7:0] t2,
                                           input logic [7:0] t3,
                                           input logic [7:0] t4);
    logic down;
    logic [2:0] nz;
    down = (tgt < cur);
    nz = down ? cur - 3'h1 : cur + 3'h1;
    // At most three zones lie between two others, so three passes suffice.
    for (int i = 0; i < 3; i++) begin
      if (nz != tgt && !zone_ok(nz, n, t1, t2, t3, t4)) begin // RULE_13
        nz = down ? nz - 3'h1 : nz + 3'h1; // RULE_11
      end
    end
    step_zone = nz;
  endfunction : step_zone

  // Register writes from software.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        thr_q[i] <= pzs_pkg::THR_DISABLED;
      end
      hyst_q <= pzs_pkg::HYST_RESET; // RULE_10
      delay_q <= pzs_pkg::DELAY_RESET;
      switchingFrequencySetting <= pzs_pkg::FREQ_RESET;
      fixedZone_q <= pzs_pkg::FIXED_RESET;
      phases_q <= pzs_pkg::PHASES_RESET;
    end else if (regReq.wr) begin
      unique case (regReq.addr)
        pzs_pkg::ADDR_THR1: thr_q[0] <= regReq.wdata; // RULE_17
        pzs_pkg::ADDR_THR2: thr_q[1] <= regReq.wdata;
        pzs_pkg::ADDR_THR3: thr_q[2] <= regReq.wdata;
        pzs_pkg::ADDR_THR4: thr_q[3] <= regReq.wdata;
        pzs_pkg::ADDR_HYST: hyst_q <= regReq.wdata; // RULE_10
        pzs_pkg::ADDR_DELAY: delay_q <= regReq.wdata; // RULE_07
        pzs_pkg::ADDR_FREQ: switchingFrequencySetting <= regReq.wdata; // RULE_14
        pzs_pkg::ADDR_FIXED: fixedZone_q <= (regReq.wdata[2:0] > 3'h4) ?
                                            3'h4 : regReq.wdata[2:0];
        pzs_pkg::ADDR_PHASES: begin
          if (regReq.wdata[3:0] >= 4'h1 && regReq.wdata[3:0] <= 4'h8) begin
            phases_q <= regReq.wdata[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the read strobe; zero otherwise.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regReq.rd) begin
      unique case (regReq.addr)
        pzs_pkg::ADDR_THR1: regRdata <= thr_q[0];
        pzs_pkg::ADDR_THR2: regRdata <= thr_q[1];
        pzs_pkg::ADDR_THR3: regRdata <= thr_q[2];
        pzs_pkg::ADDR_THR4: regRdata <= thr_q[3];
        pzs_pkg::ADDR_HYST: regRdata <= hyst_q;
        pzs_pkg::ADDR_DELAY: regRdata <= delay_q;
        pzs_pkg::ADDR_FREQ: regRdata <= switchingFrequencySetting; // RULE_14
        pzs_pkg::ADDR_FIXED: regRdata <= {5'h00, fixedZone_q};
        pzs_pkg::ADDR_STATUS: regRdata <= {2'h0, target_q, zone_q};
        pzs_pkg::ADDR_PHASES: regRdata <= {4'h0, phases_q};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Free-running 10 us tick paces both sampling and shed delay steps.
  always_ff @(posedge mclk) begin
    if (!rst_n || tick_q == 16'(pzs_pkg::STEP_CYCLES - 1)) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end
  assign sample = (tick_q == 16'(pzs_pkg::STEP_CYCLES - 1));

  // Target zone selection. Auto mode updates once per sample; hysteresis
  // keeps a zone until current falls below threshold minus hysteresis.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_q <= 3'h0;
    end else if (powerSaveSelect == pzs_pkg::PZS_PS_HIGH) begin
      target_q <= 3'h0; // RULE_15
    end else if (powerSaveSelect == pzs_pkg::PZS_PS_LOW) begin
      target_q <= fixedZone_q; // RULE_12 RULE_13
    end else if (sample) begin // RULE_05 RULE_16
      logic [2:0] t;
      t = 3'h4;
      for (int k = 0; k < 4; k++) begin
        // Threshold k+1 separates zone 3-k from zone 4-k.
        if (thr_q[k] != pzs_pkg::THR_DISABLED) begin
          if (totalCurrentMonitor > thr_q[k]) begin
            t = 3'(3 - k); // RULE_09
          end else if (zone_q <= 3'(3 - k) &&
                       {1'b0, totalCurrentMonitor} + {1'b0, hyst_q} >=
                       {1'b0, thr_q[k]}) begin
            t = 3'(3 - k); // RULE_09
          end
        end
      end
      // A zone that is disabled, or that the phase count lacks, resolves to
      // the nearest lower-numbered usable zone; zone 0 is always usable.
      for (int i = 0; i < 4; i++) begin
        if (t != 3'h0 && !zone_ok(t, phases_q, thr_q[0], thr_q[1],
                                  thr_q[2], thr_q[3])) begin
          t = t - 3'h1; // RULE_11 RULE_13 RULE_17
        end
      end
      target_q <= t;
    end
  end

  // Zone stepping: one usable zone per move, rises immediate, sheds delayed.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zone_q <= 3'h0;
      stepCnt_q <= 8'h00;
    end else if (target_q < zone_q) begin
      // Rise in load: step down at once and drop any pending shed.
      zone_q <= step_zone(zone_q, target_q, phases_q, thr_q[0], thr_q[1],
                          thr_q[2], thr_q[3]); // RULE_06 RULE_08 RULE_11
      stepCnt_q <= 8'h00; // RULE_18
    end else if (target_q > zone_q) begin
      if (sample) begin
        if (stepCnt_q + 8'h01 >= delay_q) begin
          zone_q <= step_zone(zone_q, target_q, phases_q, thr_q[0],
                              thr_q[1], thr_q[2], thr_q[3]); // RULE_07 RULE_08
          stepCnt_q <= 8'h00; // RULE_18
        end else begin
          stepCnt_q <= stepCnt_q + 8'h01;
        end
      end
    end else begin
      stepCnt_q <= 8'h00; // RULE_18
    end
  end

  assign phaseEn_d = phase_map(zone_q, phases_q); // RULE_19

  // Usability of the zone just above the present one, for the step check.
  assign upNextOk = zone_ok(zone_q + 3'h1, phases_q, thr_q[0], thr_q[1],
                            thr_q[2], thr_q[3]);

  // Outputs registered from the encoded zone.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phaseEnable <= 8'hFF;
      dcmMode <= 1'b0;
      zone <= 3'h0;
    end else begin
      phaseEnable <= phaseEn_d; // RULE_19
      dcmMode <= (zone_q == pzs_pkg::ZONE_DCM); // RULE_04
      zone <= zone_q;
    end
  end

  // Zone engine checks; all but a_dcm_zone, a_phase_one_on, a_phase_map and a_zone_range look at registered state one edge later.
  a_zone_single_step: assert property ( // RULE_08 RULE_11
    @(posedge mclk) disable iff (!rst_n)
    zone_q > $past(zone_q) |-> zone_q <= $past(target_q) &&
    (zone_q == $past(zone_q) + 3'h1 || !$past(upNextOk)))
    else $error("shed step passed a usable zone");
  a_rise_bounded: assert property ( // RULE_06 RULE_11
    @(posedge mclk) disable iff (!rst_n)
    zone_q < $past(zone_q) |-> zone_q >= $past(target_q))
    else $error("rise step passed the target");
  a_shed_needs_tick: assert property ( // RULE_07
    @(posedge mclk) disable iff (!rst_n)
    zone_q > $past(zone_q) |-> $past(sample))
    else $error("shed step without tick");
  a_rise_immediate: assert property ( // RULE_06
    @(posedge mclk) disable iff (!rst_n)
    target_q < zone_q |=> zone_q < $past(zone_q))
    else $error("rise step delayed");
  a_high_all_on: assert property ( // RULE_15
    @(posedge mclk) disable iff (!rst_n)
    powerSaveSelect == pzs_pkg::PZS_PS_HIGH |=> target_q == 3'h0)
    else $error("high level not zone zero");
  a_dcm_zone: assert property ( // RULE_04
    @(posedge mclk) disable iff (!rst_n)
    dcmMode == (zone == pzs_pkg::ZONE_DCM))
    else $error("dcm flag mismatch");
  a_phase_one_on: assert property ( // RULE_01
    @(posedge mclk) disable iff (!rst_n)
    phaseEnable[0])
    else $error("phase one off");
  a_fixed_target: assert property ( // RULE_12
    @(posedge mclk) disable iff (!rst_n)
    powerSaveSelect == pzs_pkg::PZS_PS_LOW |=>
    target_q == $past(fixedZone_q))
    else $error("fixed target not followed");
  a_phase_map: assert property ( // RULE_01 RULE_02 RULE_03
    @(posedge mclk) disable iff (!rst_n)
    zone == pzs_pkg::ZONE_DCM |-> phaseEnable == 8'h01)
    else $error("light load zone not single phase");
  a_zone_range: assert property ( // RULE_19
    @(posedge mclk) disable iff (!rst_n)
    zone_q <= pzs_pkg::ZONE_DCM)
    else $error("zone code out of range");
endmodule : pzs_zone_ctrl

// File: bench/pzs_load_model.sv
// Purpose: Host and load stand-in that feeds the zone controller.
// Assumes: The bench sets the wanted load and power-save level at edges.
// Notes: Outputs are registered, so the block sees a converter-like lag.
`timescale 1ns/100ps
module pzs_load_model (
  input wire logic mclk,
  input wire logic [7:0] loadLevel,
  input wire pzs_pkg::pzs_psave_t modeReq,
  output logic [7:0] totalCurrentMonitor,
  output pzs_pkg::pzs_psave_t powerSaveSelect
);
  // One cycle of lag mimics a sampled monitor; it never answers early.
  always_ff @(posedge mclk) begin
    totalCurrentMonitor <= loadLevel;
    powerSaveSelect <= modeReq;
  end
endmodule : pzs_load_model

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the zone controller.
// Assumes: 50 MHz mclk, register port with read data one cycle later.
// Notes: Shed delay is set to one or two steps to keep the run short.
`timescale 1ns/100ps
module tb_top;
  logic mclk;
  logic rst_n;
  logic [7:0] loadLevel;
  pzs_pkg::pzs_psave_t modeReq;
  logic [7:0] totalCurrentMonitor;
  pzs_pkg::pzs_psave_t powerSaveSelect;
  pzs_pkg::pzs_req_t regReq;
  logic [7:0] regRdata;
  logic [7:0] phaseEnable;
  logic dcmMode;
  logic [7:0] switchingFrequencySetting;
  logic [2:0] zone;
  logic [4:0] seen;
  logic [7:0] rdVal;
  logic [7:0] resetVals [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h10, 8'h14,
    8'h00, 8'h00, 8'h00, 8'h08};
  int bad_count = 0;
  int cmp_count = 0;

  pzs_load_model pzs_load_model_inst (.mclk(mclk), .loadLevel(loadLevel),
    .modeReq(modeReq), .totalCurrentMonitor(totalCurrentMonitor),
    .powerSaveSelect(powerSaveSelect));
  pzs_zone_ctrl pzs_zone_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
    .powerSaveSelect(powerSaveSelect),
    .totalCurrentMonitor(totalCurrentMonitor), .regReq(regReq),
    .regRdata(regRdata), .phaseEnable(phaseEnable), .dcmMode(dcmMode),
    .switchingFrequencySetting(switchingFrequencySetting), .zone(zone));

  // Free-running 20 ns clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check8

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    regReq.wr <= 1'b0;
  endtask : regWrite

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask : regRead

  // Waits a bounded time for a zone and records every zone passed on the way.
  task automatic waitZone(input logic [2:0] z, input int lim);
    int n;
    n = 0;
    seen = 5'h00;
    seen[zone] = 1'b1;
    while (zone !== z && n < lim) begin
      @(posedge mclk);
      #1 seen[zone] = 1'b1;
      n++;
    end
    check8({5'h00, zone}, {5'h00, z}, "zone");
  endtask : waitZone

  function automatic logic [7:0] expPhases(input int n, input int z);
    case (z)
      0: return 8'hFF >> (8 - n);
      1: return 8'h55;
      2: return (n == 8) ? 8'h11 : ((n == 6) ? 8'h15 : 8'h05);
      default: return 8'h01;
    endcase
  endfunction : expPhases

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Watchdog sized well above the roughly 30k cycles the tests need.
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    regReq = '0;
    loadLevel = 8'h00;
    modeReq = pzs_pkg::PZS_PS_HIGH;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      regRead(4'(i), rdVal);
      if (i != 8) check8(rdVal, resetVals[i], "reset value");
    end
    regRead(4'hF, rdVal);
    check8(rdVal, 8'h00, "unmapped read");
    regWrite(pzs_pkg::ADDR_FREQ, 8'h5A);
    regRead(pzs_pkg::ADDR_FREQ, rdVal);
    check8(rdVal, 8'h5A, "freq readback");
    check8(switchingFrequencySetting, 8'h5A, "freq out");
    regWrite(pzs_pkg::ADDR_HYST, 8'h22);
    regRead(pzs_pkg::ADDR_HYST, rdVal);
    check8(rdVal, 8'h22, "hyst readback");
    regWrite(pzs_pkg::ADDR_HYST, pzs_pkg::HYST_RESET);
    regWrite(pzs_pkg::ADDR_PHASES, 8'h09);
    regRead(pzs_pkg::ADDR_PHASES, rdVal);
    check8(rdVal, 8'h08, "phase count refuse");
    // High level with no load must still keep every phase on.
    repeat (1200) @(posedge mclk);
    #1 check8(phaseEnable, 8'hFF, "high level phases");
    regWrite(pzs_pkg::ADDR_DELAY, 8'h01);
    modeReq <= pzs_pkg::PZS_PS_LOW;
    // Fixed zones walked per phase count; only zones the table defines.
    for (int n = 8; n >= 1; n--) begin
      regWrite(pzs_pkg::ADDR_PHASES, 8'(n));
      for (int z = 4; z >= 0; z--) begin
        if ((z == 1 && n != 8) || (z == 3 && n == 1)) continue;
        if (z == 2 && n != 8 && n != 6 && n != 4) continue;
        regWrite(pzs_pkg::ADDR_FIXED, 8'(z));
        waitZone(3'(z), 6000);
        repeat (2) @(posedge mclk);
        #1 check8(phaseEnable, expPhases(n, z), "phases");
        check8({7'h00, dcmMode}, {7'h00, z == 4}, "dcm");
      end
    end
    // Automatic shedding with eight phases and two-step shed delay.
    regWrite(pzs_pkg::ADDR_PHASES, 8'h08);
    for (int i = 0; i < 4; i++) begin
      regWrite(pzs_pkg::ADDR_THR1 + 4'(i), 8'h20 * 8'(i + 1));
    end
    regWrite(pzs_pkg::ADDR_DELAY, 8'h02);
    modeReq <= pzs_pkg::PZS_PS_MID;
    loadLevel <= 8'h08;
    repeat (450) @(posedge mclk);
    #1 check8({5'h00, zone}, 8'h00, "shed too early");
    waitZone(3'h4, 6000);
    check8({3'h0, seen}, 8'h1F, "shed path");
    loadLevel <= 8'h90;
    waitZone(3'h0, 520);
    loadLevel <= 8'h08;
    waitZone(3'h4, 6000);
    loadLevel <= 8'h21;
    waitZone(3'h3, 520);
    loadLevel <= 8'h18;
    repeat (2500) @(posedge mclk);
    #1 check8({5'h00, zone}, 8'h03, "hysteresis hold");
    regRead(pzs_pkg::ADDR_STATUS, rdVal);
    check8(rdVal, 8'h1B, "status hold");
    loadLevel <= 8'h0F;
    waitZone(3'h4, 2000);
    // A disabled threshold must be stepped over; only the shed path is checked.
    regWrite(pzs_pkg::ADDR_THR3, 8'hFF);
    loadLevel <= 8'h90;
    waitZone(3'h0, 520);
    loadLevel <= 8'h08;
    waitZone(3'h4, 6000);
    check8({3'h0, seen}, 8'h1B, "skip path");
    // Fixed mode may still reach the zone that shedding has disabled.
    regWrite(pzs_pkg::ADDR_FIXED, 8'h02);
    modeReq <= pzs_pkg::PZS_PS_LOW;
    waitZone(3'h2, 3000);
    repeat (2) @(posedge mclk);
    #1 check8(phaseEnable, 8'h11, "fixed disabled zone");
    modeReq <= pzs_pkg::PZS_PS_MID;
    loadLevel <= 8'h50;
    repeat (3000) @(posedge mclk);
    #1 check8({7'h00, zone != 3'h2}, 8'h01, "zone disabled again");
    summarize();
  end
endmodule : tb_top
